// ### core/pwr_seq_pkg.sv
package pwr_seq_pkg;

    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int TIMER_W = 20;
    localparam int EVT_W = 3;

    // register offsets
    localparam logic [ADDR_W-1:0] IRQ_CFG_ADDR = 8'h05;
    localparam logic [ADDR_W-1:0] WAKE_EN_ADDR = 8'h1c;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h20;
    localparam logic [ADDR_W-1:0] INT_STATUS_ADDR = 8'h21;
    localparam logic [ADDR_W-1:0] INT_MASK_ADDR = 8'h22;
    localparam logic [ADDR_W-1:0] SEQ_STATE_ADDR = 8'h23;

    // field positions
    localparam int IRQ_POL_BIT = 0;
    localparam int IRQ_OPEN_DRAIN_BIT = 1;
    localparam int WAKE_EN_BIT = 0;
    localparam int CLK_OUT_EN_BIT = 0;
    localparam int EVT_WAKE_BIT = 0;
    localparam int EVT_STABLE_BIT = 1;
    localparam int EVT_SLEEP_BIT = 2;

    // reset values
    localparam logic [DATA_W-1:0] IRQ_CFG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] WAKE_EN_RESET = 8'h00;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h01;
    localparam logic [EVT_W-1:0] INT_STATUS_RESET = 3'h0;
    localparam logic [EVT_W-1:0] INT_MASK_RESET = 3'h0;

    // timing, each figure in its own unit, counts derived at 250 MHz
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SLEEP_ENTRY_DELAY_NS = 50;
    localparam int WAKE_CLOCK_DELAY_US = 2000;
    localparam int WAKE_INTERRUPT_DELAY_US = 2000;
    localparam int CLOCK_SETTLE_DELAY_US = 2100;
    localparam int SLEEP_ENTRY_CYCLES = SLEEP_ENTRY_DELAY_NS * 1000 / CLK_PERIOD_PS;
    localparam int WAKE_CLOCK_CYCLES = WAKE_CLOCK_DELAY_US * 1000 / (CLK_PERIOD_PS / 1000);
    localparam int WAKE_INTERRUPT_CYCLES =
        WAKE_INTERRUPT_DELAY_US * 1000 / (CLK_PERIOD_PS / 1000);
    localparam int CLOCK_SETTLE_CYCLES =
        CLOCK_SETTLE_DELAY_US * 1000 / (CLK_PERIOD_PS / 1000);

    // sequencer states
    typedef enum logic [2:0] {
        ST_SLEEP_ENTRY = 3'b000,
        ST_SLEEP = 3'b001,
        ST_WAKING = 3'b010,
        ST_SETTLING = 3'b011,
        ST_STABLE = 3'b100
    } seq_state_t;

    // two-stage synchroniser state
    typedef struct packed {
        logic meta;
        logic sync;
    } sync_state_t;

    // delay timer state
    typedef struct packed {
        logic running;
        logic expired;
        logic [TIMER_W-1:0] cnt;
    } timer_state_t;

    // sequencer state, registers and registered outputs
    typedef struct packed {
        seq_state_t st;
        logic pd_prev;
        logic wake_armed;
        logic low_pwr;
        logic clk_run;
        logic clk_out;
        logic stable;
        logic [DATA_W-1:0] irq_cfg;
        logic [DATA_W-1:0] wake_en;
        logic [DATA_W-1:0] ctrl;
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] mask;
        logic irq;
        logic irq_out;
        logic irq_oe;
        logic [DATA_W-1:0] rdata;
    } seq_regs_t;

endpackage

// ### core/level_sync.sv
`timescale 1ns/1ps
// two flip-flops between a pin and any logic
module level_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    output logic sync_o
);

    pwr_seq_pkg::sync_state_t q;
    pwr_seq_pkg::sync_state_t d;

    // the first stage feeds only the second
    always_comb begin
        d.meta = async_i;
        d.sync = q.meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // both stages reset to the level that the pin is known to idle at
            q <= '{meta: RESET_VAL, sync: RESET_VAL};
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.sync;

endmodule

// ### core/delay_timer.sv
`timescale 1ns/1ps
// one-shot delay: done_o rises CYCLES edges after the start edge
module delay_timer #(
    parameter int unsigned CYCLES = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic abort_i,
    output logic done_o
);

    localparam logic [pwr_seq_pkg::TIMER_W-1:0] LOAD =
        pwr_seq_pkg::TIMER_W'(CYCLES - 1);

    pwr_seq_pkg::timer_state_t q;
    pwr_seq_pkg::timer_state_t d;

    // start wins over abort so a restart is never lost
    always_comb begin
        d = q;
        if (start_i) begin
            d.running = 1'b1;
            d.expired = 1'b0;
            d.cnt = LOAD;
        end else if (abort_i) begin
            d = '0;
        end else if (q.running) begin
            if (q.cnt == '0) begin
                d.running = 1'b0;
                d.expired = 1'b1;
            end else begin
                d.cnt = q.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign done_o = q.expired;

endmodule

// ### core/power_down_wake_sequencer.sv
`timescale 1ns/1ps
// What this block does
// - asserting power-down puts the device in low-power mode in about 50 ns.
// - about 2000 us after power-down release the clocks and clock output run.
// - a release of power-down seen in sleep produces a wakeup event, unless power-down returns within the wake delay.
// - with wake enable bit 0 set, the wakeup event drives the IRQ pin at 2000 us.
// - the clock is reported settled about 2100 us after power-down release.
// - IRQ pin polarity and drive method follow bits 1:0 of the config register.
module power_down_wake_sequencer #(
    parameter int unsigned WAKE_CYCLES = pwr_seq_pkg::WAKE_INTERRUPT_CYCLES,
    parameter int unsigned SETTLE_CYCLES = pwr_seq_pkg::CLOCK_SETTLE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic power_down_pin_i,
    input wire logic [pwr_seq_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [pwr_seq_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [pwr_seq_pkg::DATA_W-1:0] reg_rdata_o,
    output logic low_power_o,
    output logic clocks_running_o,
    output logic crystal_clock_output_o,
    output logic clock_stable_o,
    output logic irq_o,
    output logic irq_pin_o,
    output logic irq_pin_oe_o
);

    localparam pwr_seq_pkg::seq_regs_t REGS_RESET = '{
        st: pwr_seq_pkg::ST_SLEEP,
        pd_prev: 1'b0,
        wake_armed: 1'b0,
        low_pwr: 1'b1,
        clk_run: 1'b0,
        clk_out: 1'b0,
        stable: 1'b0,
        irq_cfg: pwr_seq_pkg::IRQ_CFG_RESET,
        wake_en: pwr_seq_pkg::WAKE_EN_RESET,
        ctrl: pwr_seq_pkg::CTRL_RESET,
        status: pwr_seq_pkg::INT_STATUS_RESET,
        mask: pwr_seq_pkg::INT_MASK_RESET,
        irq: 1'b0,
        irq_out: 1'b1,
        irq_oe: 1'b1,
        rdata: '0
    };

    pwr_seq_pkg::seq_regs_t q;
    pwr_seq_pkg::seq_regs_t d;

    logic pd;
    logic sleep_go;
    logic wake_go;
    logic sleep_done;
    logic wake_done;
    logic settle_done;
    logic level;
    logic [pwr_seq_pkg::EVT_W-1:0] set_bits;
    logic [pwr_seq_pkg::EVT_W-1:0] clr_bits;
    logic [pwr_seq_pkg::EVT_W-1:0] eff_mask;

    // the power-down pin comes from the host, off this clock; the pipe resets
    // to asserted so that leaving reset never looks like a release
    level_sync #(
        .RESET_VAL(1'b1)
    ) u_pd_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(power_down_pin_i),
        .sync_o(pd)
    );

    // low-power entry delay
    delay_timer #(
        .CYCLES(pwr_seq_pkg::SLEEP_ENTRY_CYCLES)
    ) u_sleep_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_i(sleep_go),
        .abort_i(1'b0),
        .done_o(sleep_done)
    );

    // clocks-running and wake interrupt delay
    delay_timer #(
        .CYCLES(WAKE_CYCLES)
    ) u_wake_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_i(wake_go),
        .abort_i(sleep_go),
        .done_o(wake_done)
    );

    // clock settle delay, counted from the same release edge
    delay_timer #(
        .CYCLES(SETTLE_CYCLES)
    ) u_settle_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_i(wake_go),
        .abort_i(sleep_go),
        .done_o(settle_done)
    );

    // sequencer, register file and irq pin shaping
    always_comb begin
        d = q;
        sleep_go = 1'b0;
        wake_go = 1'b0;
        set_bits = '0;
        clr_bits = '0;
        d.rdata = '0;
        d.pd_prev = pd;

        case (q.st)
            pwr_seq_pkg::ST_SLEEP_ENTRY: begin
                if (sleep_done) begin
                    d.st = pwr_seq_pkg::ST_SLEEP;
                    d.low_pwr = 1'b1;
                    set_bits[pwr_seq_pkg::EVT_SLEEP_BIT] = 1'b1;
                end
            end
            pwr_seq_pkg::ST_SLEEP: begin
                if (!pd) begin
                    d.st = pwr_seq_pkg::ST_WAKING;
                    d.low_pwr = 1'b0;
                    wake_go = 1'b1;
                    // armed by an asserted level seen before; the pipe resets high
                    d.wake_armed = q.pd_prev;
                end
            end
            pwr_seq_pkg::ST_WAKING: begin
                if (wake_done) begin
                    d.st = pwr_seq_pkg::ST_SETTLING;
                    d.clk_run = 1'b1;
                    if (q.wake_armed) begin
                        set_bits[pwr_seq_pkg::EVT_WAKE_BIT] = 1'b1;
                    end
                end
            end
            pwr_seq_pkg::ST_SETTLING: begin
                if (settle_done) begin
                    d.st = pwr_seq_pkg::ST_STABLE;
                    d.stable = 1'b1;
                    set_bits[pwr_seq_pkg::EVT_STABLE_BIT] = 1'b1;
                end
            end
            pwr_seq_pkg::ST_STABLE: begin
                d.st = pwr_seq_pkg::ST_STABLE;
            end
            default: begin
                d.st = pwr_seq_pkg::ST_SLEEP_ENTRY;
                sleep_go = 1'b1;
            end
        endcase

        // power-down overrides every awake state; clocks stop at once
        if (pd && q.st != pwr_seq_pkg::ST_SLEEP_ENTRY && q.st != pwr_seq_pkg::ST_SLEEP) begin
            d.st = pwr_seq_pkg::ST_SLEEP_ENTRY;
            sleep_go = 1'b1;
            d.clk_run = 1'b0;
            d.stable = 1'b0;
            d.wake_armed = 1'b0;
        end

        // register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                pwr_seq_pkg::IRQ_CFG_ADDR: d.irq_cfg = reg_wdata_i;
                pwr_seq_pkg::WAKE_EN_ADDR: d.wake_en = reg_wdata_i;
                pwr_seq_pkg::CTRL_ADDR: d.ctrl = reg_wdata_i;
                pwr_seq_pkg::INT_STATUS_ADDR: clr_bits = reg_wdata_i[pwr_seq_pkg::EVT_W-1:0];
                pwr_seq_pkg::INT_MASK_ADDR: d.mask = reg_wdata_i[pwr_seq_pkg::EVT_W-1:0];
                default: d.ctrl = q.ctrl;
            endcase
        end

        // sticky status: a new event beats a write-one-to-clear
        d.status = (q.status & ~clr_bits) | set_bits;

        // reads answer one cycle later, zero for unmapped offsets
        if (reg_rd_i) begin
            case (reg_addr_i)
                pwr_seq_pkg::IRQ_CFG_ADDR: d.rdata = q.irq_cfg;
                pwr_seq_pkg::WAKE_EN_ADDR: d.rdata = q.wake_en;
                pwr_seq_pkg::CTRL_ADDR: d.rdata = q.ctrl;
                pwr_seq_pkg::INT_STATUS_ADDR: d.rdata = {5'h00, q.status};
                pwr_seq_pkg::INT_MASK_ADDR: d.rdata = {5'h00, q.mask};
                pwr_seq_pkg::SEQ_STATE_ADDR: begin
                    d.rdata = {4'h0, q.stable, q.clk_run, q.low_pwr, pd};
                end
                default: d.rdata = '0;
            endcase
        end

        // clock output only runs while the clocks do and it is enabled
        d.clk_out = d.clk_run & d.ctrl[pwr_seq_pkg::CLK_OUT_EN_BIT];

        // the wake enable bit unmasks the wake event in addition to the mask
        eff_mask = d.mask;
        eff_mask[pwr_seq_pkg::EVT_WAKE_BIT] = d.mask[pwr_seq_pkg::EVT_WAKE_BIT]
            | d.wake_en[pwr_seq_pkg::WAKE_EN_BIT];
        d.irq = |(d.status & eff_mask);

        // pin level from polarity, then push-pull or open-drain drive
        level = ~(d.irq ^ d.irq_cfg[pwr_seq_pkg::IRQ_POL_BIT]);
        if (d.irq_cfg[pwr_seq_pkg::IRQ_OPEN_DRAIN_BIT]) begin
            d.irq_out = 1'b0;
            d.irq_oe = ~level;
        end else begin
            d.irq_out = level;
            d.irq_oe = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= REGS_RESET;
        end else begin
            q <= d;
        end
    end

    // all outputs straight from flip-flops
    assign reg_rdata_o = q.rdata;
    assign low_power_o = q.low_pwr;
    assign clocks_running_o = q.clk_run;
    assign crystal_clock_output_o = q.clk_out;
    assign clock_stable_o = q.stable;
    assign irq_o = q.irq;
    assign irq_pin_o = q.irq_out;
    assign irq_pin_oe_o = q.irq_oe;

    // helper for the checks: cycles spent awake since the last release
    logic [pwr_seq_pkg::TIMER_W-1:0] age_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            age_q <= '0;
        end else if (q.st == pwr_seq_pkg::ST_SLEEP || q.st == pwr_seq_pkg::ST_SLEEP_ENTRY) begin
            age_q <= '0;
        end else if (age_q != '1) begin
            age_q <= age_q + 1'b1;
        end
    end

    localparam int SLEEP_BOUND = pwr_seq_pkg::SLEEP_ENTRY_CYCLES + 2;
    localparam logic [pwr_seq_pkg::TIMER_W-1:0] WAKE_AGE =
        pwr_seq_pkg::TIMER_W'(WAKE_CYCLES + 1);
    localparam logic [pwr_seq_pkg::TIMER_W-1:0] SETTLE_AGE =
        pwr_seq_pkg::TIMER_W'(SETTLE_CYCLES + 1);

    // power-down seen high while the device is awake
    sequence pd_assert_s;
        $rose(pd) && q.st != pwr_seq_pkg::ST_SLEEP;
    endsequence

    // power-down released out of sleep after a genuine assertion
    sequence pd_release_s;
        q.st == pwr_seq_pkg::ST_SLEEP && q.pd_prev && !pd;
    endsequence

    // the release is followed by the waking state with the event armed
    sequence wake_start_s;
        ##1 (q.st == pwr_seq_pkg::ST_WAKING && q.wake_armed);
    endsequence

    a_sleep_entry_time: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        pd_assert_s |-> ##[1:SLEEP_BOUND] low_power_o
    ) else $error("low power not reached after power-down");

    a_sleep_stops_clocks: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        low_power_o |-> !clocks_running_o && !clock_stable_o
    ) else $error("clocks still flagged while in low power");

    a_wake_clock_time: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(clocks_running_o) |-> age_q == WAKE_AGE
    ) else $error("clocks started at the wrong time");

    a_clock_out_gate: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        crystal_clock_output_o |-> clocks_running_o
            && q.ctrl[pwr_seq_pkg::CLK_OUT_EN_BIT]
    ) else $error("clock output active without running clocks");

    a_wake_event_arm: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        pd_release_s |-> wake_start_s
    ) else $error("power-down release did not arm a wake event");

    a_wake_irq_pin: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(q.status[pwr_seq_pkg::EVT_WAKE_BIT])
            && q.wake_en[pwr_seq_pkg::WAKE_EN_BIT]
            |-> irq_o && $rose(clocks_running_o)
    ) else $error("wake interrupt not raised with the clocks");

    a_settle_time: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(clock_stable_o) |-> age_q == SETTLE_AGE && clocks_running_o
    ) else $error("clock stable flagged at the wrong time");

    a_irq_push_pull: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !q.irq_cfg[pwr_seq_pkg::IRQ_OPEN_DRAIN_BIT] |->
            irq_pin_oe_o && irq_pin_o == (irq_o == q.irq_cfg[pwr_seq_pkg::IRQ_POL_BIT])
    ) else $error("push-pull irq pin level wrong");

    a_irq_open_drain: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        q.irq_cfg[pwr_seq_pkg::IRQ_OPEN_DRAIN_BIT] |->
            !irq_pin_o && irq_pin_oe_o == (irq_o != q.irq_cfg[pwr_seq_pkg::IRQ_POL_BIT])
    ) else $error("open-drain irq pin drive wrong");

    a_read_one_cycle: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !reg_rd_i |=> reg_rdata_o == '0
    ) else $error("read data outside its cycle");

endmodule

// ### verif/host_pd_model.sv
`timescale 1ns/1ps
// host side of the power-down pin; it never makes a pulse shorter than
// allowed, so the bench asks for a level and the model times the change
module host_pd_model #(
    parameter int unsigned POR_CYCLES = 20,
    parameter int unsigned MIN_CYCLES = 8
) (
    input wire logic clk_i,
    input wire logic want_sleep_i,
    output logic power_down_pin_o
);
    int unsigned hold_q = POR_CYCLES;
    logic pin_q = 1'b1;

    // asserted from power-on so the oscillator starts cleanly
    assign power_down_pin_o = pin_q;

    // a requested change waits until the present level has lasted long enough
    always @(posedge clk_i) begin
        if (hold_q != 0) begin
            hold_q <= hold_q - 1;
        end else if (want_sleep_i != pin_q) begin
            pin_q <= want_sleep_i;
            hold_q <= MIN_CYCLES;
        end
    end
endmodule

// ### verif/power_down_wake_sequencer_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) \
    begin \
        n_checks++; \
        if ((a) !== (e)) begin \
            err_count++; \
            $display("unexpected %s: expected %0h seen %0h", nm, e, a); \
        end \
    end

module power_down_wake_sequencer_tb_top;
    // short counts keep the run small; expectations follow from them
    localparam int W = 40;
    localparam int S = 60;
    localparam int RUN = 3 + W + 1;
    localparam int STB = 3 + S + 1;
    localparam int ENT = 2 + pwr_seq_pkg::SLEEP_ENTRY_CYCLES + 2;
    localparam int GUARD = 250;
    localparam logic [7:0] A_CFG = pwr_seq_pkg::IRQ_CFG_ADDR;
    localparam logic [7:0] A_WEN = pwr_seq_pkg::WAKE_EN_ADDR;
    localparam logic [7:0] A_CTL = pwr_seq_pkg::CTRL_ADDR;
    localparam logic [7:0] A_STS = pwr_seq_pkg::INT_STATUS_ADDR;
    localparam logic [7:0] A_MSK = pwr_seq_pkg::INT_MASK_ADDR;
    localparam logic [7:0] A_ST = pwr_seq_pkg::SEQ_STATE_ADDR;

    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic want_sleep = 1'b1;
    logic pd_pin;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic low_power, running, clk_out, stable, irq, irq_pin, irq_oe;
    logic [4:0] obs;
    int err_count = 0;
    int n_checks = 0;
    int first[5];

    always #2 clk_i = ~clk_i;

    // bit order matches the expectation lists of move_pin
    assign obs = {irq, stable, clk_out, running, low_power};

    host_pd_model #(.POR_CYCLES(20), .MIN_CYCLES(8)) i_host (
        .clk_i(clk_i),
        .want_sleep_i(want_sleep),
        .power_down_pin_o(pd_pin)
    );

    power_down_wake_sequencer #(.WAKE_CYCLES(W), .SETTLE_CYCLES(S)) i_dut (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .power_down_pin_i(pd_pin),
        .reg_addr_i(addr),
        .reg_wdata_i(wdata),
        .reg_wr_i(wr),
        .reg_rd_i(rd),
        .reg_rdata_o(rdata),
        .low_power_o(low_power),
        .clocks_running_o(running),
        .crystal_clock_output_o(clk_out),
        .clock_stable_o(stable),
        .irq_o(irq),
        .irq_pin_o(irq_pin),
        .irq_pin_oe_o(irq_oe)
    );

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one-cycle write; strobe dropped a cycle before the next request
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        #1;
        wr <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    // read data stand only in the cycle after the strobe, zero after that
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        #1;
        rd <= 1'b0;
        `CHK(nm, e, rdata)
        @(posedge clk_i);
        #1;
        `CHK(nm, 8'h00, rdata)
    endtask

    // move the pin, then note the edge at which each output first changes
    task automatic move_pin(input logic v, input int e[5]);
        logic [4:0] start;
        int n;
        string nm[5] = '{"low_power", "running", "clock_out", "stable", "irq"};
        want_sleep <= v;
        n = 0;
        while (pd_pin !== v && n < 40) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (pd_pin !== v) begin
            err_count++;
            stop_test();
        end
        start = obs;
        for (int i = 0; i < 5; i++) first[i] = -1;
        for (n = 1; n <= 80; n++) begin
            @(posedge clk_i);
            #1;
            for (int i = 0; i < 5; i++) begin
                if (first[i] < 0 && obs[i] !== start[i]) first[i] = n;
            end
        end
        for (int i = 0; i < 5; i++) `CHK(nm[i], e[i], first[i])
    endtask

    // reset values, read-back, read-only and unmapped places
    task automatic t_regs();
        rd_chk("irq_cfg", A_CFG, 8'h00);
        rd_chk("wake_en", A_WEN, 8'h00);
        rd_chk("ctrl", A_CTL, 8'h01);
        rd_chk("status", A_STS, 8'h00);
        rd_chk("mask", A_MSK, 8'h00);
        rd_chk("state", A_ST, 8'h03);
        wr_reg(A_CFG, 8'ha5);
        rd_chk("irq_cfg", A_CFG, 8'ha5);
        wr_reg(A_CFG, 8'h00);
        wr_reg(A_MSK, 8'hff);
        rd_chk("mask", A_MSK, 8'h07);
        wr_reg(A_ST, 8'h00);
        rd_chk("state", A_ST, 8'h03);
        wr_reg(8'h40, 8'hff);
        rd_chk("unmapped", 8'h40, 8'h00);
        $display("test regs done");
    endtask

    // release with the wake interrupt enabled, then clear it
    task automatic t_wake_irq();
        wr_reg(A_WEN, 8'h01);
        rd_chk("wake_en", A_WEN, 8'h01);
        wr_reg(A_MSK, 8'h00);
        move_pin(1'b0, '{3, RUN, RUN, STB, RUN});
        repeat (GUARD) @(posedge clk_i);
        #1;
        rd_chk("status", A_STS, 8'h03);
        rd_chk("state", A_ST, 8'h0c);
        wr_reg(A_STS, 8'h01);
        rd_chk("status", A_STS, 8'h02);
        `CHK("irq", 1'b0, irq)
        $display("test wake_irq done");
    endtask

    // sleep entry with its event unmasked onto the interrupt
    task automatic t_sleep();
        wr_reg(A_MSK, 8'h04);
        move_pin(1'b1, '{ENT, 3, 3, 3, ENT});
        rd_chk("status", A_STS, 8'h06);
        rd_chk("state", A_ST, 8'h03);
        wr_reg(A_STS, 8'h07);
        rd_chk("status", A_STS, 8'h00);
        `CHK("irq", 1'b0, irq)
        $display("test sleep done");
    endtask

    // wake with interrupt and clock output disabled: event still recorded
    task automatic t_wake_quiet();
        wr_reg(A_WEN, 8'h00);
        wr_reg(A_MSK, 8'h00);
        wr_reg(A_CTL, 8'h00);
        move_pin(1'b0, '{3, RUN, -1, STB, -1});
        repeat (GUARD) @(posedge clk_i);
        #1;
        rd_chk("status", A_STS, 8'h03);
        $display("test wake_quiet done");
    endtask

    // every polarity and drive method, with the interrupt low and high
    task automatic t_irq_pin();
        logic lvl;
        for (int c = 0; c < 4; c++) begin
            for (int l = 0; l < 2; l++) begin
                wr_reg(A_MSK, {7'h00, l[0]});
                wr_reg(A_CFG, c[7:0]);
                lvl = l[0] ? c[0] : !c[0];
                `CHK("irq", l[0], irq)
                `CHK("irq_pin", c[1] ? 1'b0 : lvl, irq_pin)
                `CHK("irq_oe", c[1] ? !lvl : 1'b1, irq_oe)
            end
        end
        wr_reg(A_STS, 8'h03);
        rd_chk("status", A_STS, 8'h00);
        wr_reg(A_CFG, 8'h00);
        wr_reg(A_CTL, 8'h01);
        $display("test irq_pin done");
    endtask

    // power-down back inside the wake delay, then a reset while asleep
    task automatic t_abort();
        move_pin(1'b1, '{ENT, 3, 3, 3, -1});
        wr_reg(A_STS, 8'h07);
        want_sleep <= 1'b0;
        repeat (12) @(posedge clk_i);
        #1;
        `CHK("low_power", 1'b0, low_power)
        want_sleep <= 1'b1;
        repeat (70) @(posedge clk_i);
        #1;
        `CHK("running", 1'b0, running)
        `CHK("low_power", 1'b1, low_power)
        rd_chk("status", A_STS, 8'h04);
        rst_n_i <= 1'b0;
        @(posedge clk_i);
        #1;
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        rd_chk("state", A_ST, 8'h03);
        repeat (20) @(posedge clk_i);
        #1;
        rd_chk("status", A_STS, 8'h00);
        $display("test abort done");
    endtask

    initial begin
        @(posedge clk_i);
        #1;
        `CHK("low_power", 1'b1, low_power)
        `CHK("irq_pin", 1'b1, irq_pin)
        `CHK("irq_oe", 1'b1, irq_oe)
        @(posedge clk_i);
        #1;
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        #1;
        t_regs();
        t_wake_irq();
        t_sleep();
        t_wake_quiet();
        t_irq_pin();
        t_abort();
        stop_test();
    end
endmodule
